/* pkg/arcr_params.svh */
// Register addresses, reset values, field positions and selector codes.
`ifndef ARCR_PARAMS_SVH
`define ARCR_PARAMS_SVH

`define ARCR_ADDR_ROUTE       8'h07
`define ARCR_ADDR_BIAS        8'h08
`define ARCR_ROUTE_RESET      8'hFF
`define ARCR_BIAS_RESET       8'h00
`define ARCR_ZERO_BYTE        8'h00

`define ARCR_SRC2_MSB         7
`define ARCR_SRC2_LSB         4
`define ARCR_SRC1_MSB         3
`define ARCR_SRC1_LSB         0

`define ARCR_BIAS_RSVD_BIT    7
`define ARCR_BIAS_COMMON_BIT  6
`define ARCR_BIAS_INPUT_MSB   5
`define ARCR_BIAS_INPUT_LSB   0

`define ARCR_SEL_AIN_LAST     4'h5
`define ARCR_SEL_ALT6         4'h6
`define ARCR_SEL_ALT7         4'h7
`define ARCR_SEL_HIGH_FIRST   4'h8
`define ARCR_SEL_HIGH_LAST    4'hB
`define ARCR_SEL_COMMON       4'hC

`define ARCR_NUM_INPUTS       12
`define ARCR_NUM_BIAS_INPUTS  6
`define ARCR_ONEHOT_BASE      12'h001
`define ARCR_ONEHOT_NONE      12'h000

`endif

/* pkg/arcr_pkg.sv */
// Types shared by the analog routing control register block.
package arcr_pkg;

    typedef logic [7:0]  arcr_byte_t;
    typedef logic [3:0]  arcr_sel_t;
    typedef logic [11:0] arcr_inputs_t;

    typedef enum logic [2:0] {
        ARCR_DEST_NONE,
        ARCR_DEST_INPUT,
        ARCR_DEST_COMMON,
        ARCR_DEST_REF_POS,
        ARCR_DEST_REF_NEG
    } arcr_dest_t;

endpackage

/* hw/arcr_route_decode.sv */
// Decoder from one excitation source selector to its switch controls.
`timescale 1ns/1ps
`default_nettype none
`include "arcr_params.svh"

module arcr_route_decode
    import arcr_pkg::*;
#(
    parameter bit TWELVE_INPUT = 1'b1
) (
    input  wire arcr_sel_t    sel,
    output arcr_inputs_t      input_onehot,
    output logic              to_common,
    output logic              to_ref_pos,
    output logic              to_ref_neg,
    output logic              connected,
    output logic              unsupported,
    output arcr_dest_t        dest
);

    function automatic arcr_inputs_t onehot12(input arcr_sel_t idx);
        onehot12 = `ARCR_ONEHOT_BASE << idx;
    endfunction

    wire is_low    = (sel <= `ARCR_SEL_AIN_LAST);
    wire is_alt6   = (sel == `ARCR_SEL_ALT6);
    wire is_alt7   = (sel == `ARCR_SEL_ALT7);
    wire is_high   = (sel >= `ARCR_SEL_HIGH_FIRST)
                   && (sel <= `ARCR_SEL_HIGH_LAST);
    wire is_common = (sel == `ARCR_SEL_COMMON);

    // Codes map straight onto input indices on the large variant.
    wire input_hit = is_low
                   | ((is_alt6 | is_alt7) & TWELVE_INPUT)
                   | (is_high & TWELVE_INPUT);

    assign input_onehot = input_hit ? onehot12(sel) : `ARCR_ONEHOT_NONE;
    assign to_ref_pos   = is_alt6 & ~TWELVE_INPUT;
    assign to_ref_neg   = is_alt7 & ~TWELVE_INPUT;
    assign to_common    = is_common;
    // High input codes on the small variant open every switch.
    assign unsupported  = is_high & ~TWELVE_INPUT;
    assign connected    = input_hit | is_common
                        | to_ref_pos | to_ref_neg;
    assign dest = input_hit  ? ARCR_DEST_INPUT :
                  is_common  ? ARCR_DEST_COMMON :
                  to_ref_pos ? ARCR_DEST_REF_POS :
                  to_ref_neg ? ARCR_DEST_REF_NEG : ARCR_DEST_NONE;

endmodule // arcr_route_decode
`default_nettype wire

/* hw/arcr_regs.sv */
// Excitation current routing and sensor bias configuration registers.
//
// Summary of operation
// - The upper nibble of the current-routing register selects the output channel of the second current source and resets to all ones.
// - The lower nibble selects the channel of the first current source with the same encoding and resets to all ones.
// - Codes 0 to 5 route the current to analog inputs 0 to 5 in order.
// - Codes 6 and 7 reach inputs 6 and 7 on the twelve-input part and the alternate reference pins on the six-input part.
// - Codes 8 to 11 reach inputs 8 to 11 and exist only on the twelve-input part.
// - Code 12 reaches the common input and codes 13 to 15 leave the source disconnected, the reset state.
// - The bias register sits at address 08h and resets to 00h so no input is biased.
// - Bias bit 6 connects the mid-supply bias to the common input when set.
// - Bias bits 5 to 0 connect the bias to the analog input of the same index when set.
// - Any combination of bias bits may be set together with no priority.
// - The current-routing register sits at address 07h and resets to FFh.
`timescale 1ns/1ps
`default_nettype none
`include "arcr_params.svh"

module arcr_regs
    import arcr_pkg::*;
#(
    parameter bit TWELVE_INPUT = 1'b1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         reg_wr_en,
    input  wire logic         reg_rd_en,
    input  wire arcr_byte_t   reg_addr,
    input  wire arcr_byte_t   reg_wdata,
    output arcr_byte_t        reg_rdata,
    output logic              reg_rd_valid,
    output logic              reg_addr_hit,
    output arcr_sel_t         source1_channel_select,
    output arcr_sel_t         source2_channel_select,
    output arcr_inputs_t      src1_input_route,
    output logic              src1_common_route,
    output logic              src1_ref_pos_route,
    output logic              src1_ref_neg_route,
    output logic              src1_connected,
    output logic              src1_unsupported,
    output arcr_inputs_t      src2_input_route,
    output logic              src2_common_route,
    output logic              src2_ref_pos_route,
    output logic              src2_ref_neg_route,
    output logic              src2_connected,
    output logic              src2_unsupported,
    output logic              route_conflict,
    output logic [5:0]        bias_input_enable,
    output logic              bias_common_enable
);

    // A macro literal cannot be part-selected, so the reset byte is named.
    localparam arcr_byte_t BIAS_RESET_BYTE = `ARCR_BIAS_RESET;

    // Stored register contents.
    arcr_byte_t   current_routing_reg;
    arcr_byte_t   current_routing_next;
    arcr_byte_t   mid_supply_bias_reg;
    arcr_byte_t   mid_supply_bias_next;

    // Read port state.
    arcr_byte_t   rdata_reg;
    arcr_byte_t   rdata_next;
    logic         rd_valid_reg;
    logic         addr_hit_reg;
    logic         addr_hit_next;

    // Registered switch controls.
    arcr_inputs_t src1_input_reg;
    logic         src1_common_reg;
    logic         src1_ref_pos_reg;
    logic         src1_ref_neg_reg;
    logic         src1_conn_reg;
    logic         src1_unsup_reg;
    arcr_inputs_t src2_input_reg;
    logic         src2_common_reg;
    logic         src2_ref_pos_reg;
    logic         src2_ref_neg_reg;
    logic         src2_conn_reg;
    logic         src2_unsup_reg;
    logic         conflict_reg;
    logic         conflict_next;
    logic [5:0]   bias_input_reg;
    logic         bias_common_reg;

    // Address decode.
    wire hit_route = (reg_addr == `ARCR_ADDR_ROUTE);
    wire hit_bias  = (reg_addr == `ARCR_ADDR_BIAS);
    wire hit_any   = hit_route | hit_bias;
    wire wr_route  = reg_wr_en & hit_route;
    wire wr_bias   = reg_wr_en & hit_bias;

    // Field views of the stored registers.
    wire arcr_sel_t src2_sel =
        current_routing_reg[`ARCR_SRC2_MSB:`ARCR_SRC2_LSB];
    wire arcr_sel_t src1_sel =
        current_routing_reg[`ARCR_SRC1_MSB:`ARCR_SRC1_LSB];

    // Whole-byte write; the reserved bias bit is kept like any other.
    assign current_routing_next = wr_route ? reg_wdata
                                           : current_routing_reg;
    assign mid_supply_bias_next = wr_bias ? reg_wdata
                                          : mid_supply_bias_reg;

    // Unmapped addresses read as zero.  A read in the same cycle as a
    // write to the same address returns the value held before the write.
    assign rdata_next = !reg_rd_en ? rdata_reg :
                        hit_route  ? current_routing_reg :
                        hit_bias   ? mid_supply_bias_reg :
                                     `ARCR_ZERO_BYTE;
    assign addr_hit_next = (reg_rd_en | reg_wr_en) ? hit_any
                                                   : addr_hit_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            current_routing_reg <= `ARCR_ROUTE_RESET;
            mid_supply_bias_reg <= `ARCR_BIAS_RESET;
        end else begin
            current_routing_reg <= current_routing_next;
            mid_supply_bias_reg <= mid_supply_bias_next;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg    <= `ARCR_ZERO_BYTE;
            rd_valid_reg <= 1'b0;
            addr_hit_reg <= 1'b0;
        end else begin
            rdata_reg    <= rdata_next;
            rd_valid_reg <= reg_rd_en;
            addr_hit_reg <= addr_hit_next;
        end
    end

    // Both sources share one decoder design and hence one encoding.
    arcr_inputs_t dec1_input;
    logic         dec1_common;
    logic         dec1_ref_pos;
    logic         dec1_ref_neg;
    logic         dec1_conn;
    logic         dec1_unsup;
    arcr_inputs_t dec2_input;
    logic         dec2_common;
    logic         dec2_ref_pos;
    logic         dec2_ref_neg;
    logic         dec2_conn;
    logic         dec2_unsup;

    arcr_route_decode #(
        .TWELVE_INPUT (TWELVE_INPUT)
    ) u_dec_src1 (
        .sel          (src1_sel),
        .input_onehot (dec1_input),
        .to_common    (dec1_common),
        .to_ref_pos   (dec1_ref_pos),
        .to_ref_neg   (dec1_ref_neg),
        .connected    (dec1_conn),
        .unsupported  (dec1_unsup),
        .dest         ()
    );

    arcr_route_decode #(
        .TWELVE_INPUT (TWELVE_INPUT)
    ) u_dec_src2 (
        .sel          (src2_sel),
        .input_onehot (dec2_input),
        .to_common    (dec2_common),
        .to_ref_pos   (dec2_ref_pos),
        .to_ref_neg   (dec2_ref_neg),
        .connected    (dec2_conn),
        .unsupported  (dec2_unsup),
        .dest         ()
    );

    // Both sources driving the same pin is legal but worth flagging.
    assign conflict_next = (|(dec1_input & dec2_input))
                         | (dec1_common  & dec2_common)
                         | (dec1_ref_pos & dec2_ref_pos)
                         | (dec1_ref_neg & dec2_ref_neg);

    always_ff @(posedge clk) begin
        if (srst) begin
            src1_input_reg   <= `ARCR_ONEHOT_NONE;
            src1_common_reg  <= 1'b0;
            src1_ref_pos_reg <= 1'b0;
            src1_ref_neg_reg <= 1'b0;
            src1_conn_reg    <= 1'b0;
            src1_unsup_reg   <= 1'b0;
        end else begin
            src1_input_reg   <= dec1_input;
            src1_common_reg  <= dec1_common;
            src1_ref_pos_reg <= dec1_ref_pos;
            src1_ref_neg_reg <= dec1_ref_neg;
            src1_conn_reg    <= dec1_conn;
            src1_unsup_reg   <= dec1_unsup;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            src2_input_reg   <= `ARCR_ONEHOT_NONE;
            src2_common_reg  <= 1'b0;
            src2_ref_pos_reg <= 1'b0;
            src2_ref_neg_reg <= 1'b0;
            src2_conn_reg    <= 1'b0;
            src2_unsup_reg   <= 1'b0;
        end else begin
            src2_input_reg   <= dec2_input;
            src2_common_reg  <= dec2_common;
            src2_ref_pos_reg <= dec2_ref_pos;
            src2_ref_neg_reg <= dec2_ref_neg;
            src2_conn_reg    <= dec2_conn;
            src2_unsup_reg   <= dec2_unsup;
        end
    end

    // Each bias bit drives its own switch, so any mix may be closed.
    always_ff @(posedge clk) begin
        if (srst) begin
            bias_input_reg  <= BIAS_RESET_BYTE
                [`ARCR_BIAS_INPUT_MSB:`ARCR_BIAS_INPUT_LSB];
            bias_common_reg <= 1'b0;
            conflict_reg    <= 1'b0;
        end else begin
            bias_input_reg  <= mid_supply_bias_reg
                [`ARCR_BIAS_INPUT_MSB:`ARCR_BIAS_INPUT_LSB];
            bias_common_reg <=
                mid_supply_bias_reg[`ARCR_BIAS_COMMON_BIT];
            conflict_reg    <= conflict_next;
        end
    end

    assign reg_rdata              = rdata_reg;
    assign reg_rd_valid           = rd_valid_reg;
    assign reg_addr_hit           = addr_hit_reg;
    assign source1_channel_select = src1_sel;
    assign source2_channel_select = src2_sel;
    assign src1_input_route       = src1_input_reg;
    assign src1_common_route      = src1_common_reg;
    assign src1_ref_pos_route     = src1_ref_pos_reg;
    assign src1_ref_neg_route     = src1_ref_neg_reg;
    assign src1_connected         = src1_conn_reg;
    assign src1_unsupported       = src1_unsup_reg;
    assign src2_input_route       = src2_input_reg;
    assign src2_common_route      = src2_common_reg;
    assign src2_ref_pos_route     = src2_ref_pos_reg;
    assign src2_ref_neg_route     = src2_ref_neg_reg;
    assign src2_connected         = src2_conn_reg;
    assign src2_unsupported       = src2_unsup_reg;
    assign route_conflict         = conflict_reg;
    assign bias_input_enable      = bias_input_reg;
    assign bias_common_enable     = bias_common_reg;

endmodule // arcr_regs
`default_nettype wire

/* dv/arcr_regs_assertions.sv */
// Concurrent checks on the routing and bias register ports.
`timescale 1ns/1ps
`default_nettype none

module arcr_regs_assertions
    import arcr_pkg::*;
#(
    parameter bit TWELVE_INPUT = 1'b1
) (
    input wire logic         clk,
    input wire logic         srst,
    input wire logic         reg_wr_en,
    input wire logic         reg_rd_en,
    input wire arcr_byte_t   reg_addr,
    input wire arcr_byte_t   reg_wdata,
    input wire arcr_byte_t   reg_rdata,
    input wire logic         reg_rd_valid,
    input wire arcr_sel_t    source1_channel_select,
    input wire arcr_sel_t    source2_channel_select,
    input wire arcr_inputs_t src1_input_route,
    input wire logic         src1_common_route,
    input wire logic         src1_connected,
    input wire arcr_inputs_t src2_input_route,
    input wire logic [5:0]   bias_input_enable,
    input wire logic         bias_common_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_route_wr;
        reg_wr_en && reg_addr == 8'h07;
    endsequence
    sequence s_bias_wr;
        reg_wr_en && reg_addr == 8'h08;
    endsequence
    chk_read_valid_pulse: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read without valid pulse");
    chk_route_store: assert property (s_route_wr |=>
        {source2_channel_select, source1_channel_select} == $past(reg_wdata))
        else $error("route write not stored");
    chk_route_read: assert property (reg_rd_en && reg_addr == 8'h07
        |=>
        reg_rdata == $past({source2_channel_select, source1_channel_select}))
        else $error("route read mismatch");
    chk_low_inputs: assert property (source1_channel_select <= 4'h5
        |=> src1_input_route == (12'h001 << $past(source1_channel_select)))
        else $error("source1 input switch wrong");
    chk_high_inputs: assert property (TWELVE_INPUT &&
        source2_channel_select inside {[4'h6:4'hB]} |=>
        src2_input_route == (12'h001 << $past(source2_channel_select)))
        else $error("source2 input switch wrong");
    chk_common_route: assert property (source1_channel_select == 4'hC
        |=> src1_common_route && src1_connected)
        else $error("source1 common route missing");
    chk_source_open: assert property (source1_channel_select > 4'hC
        |=> !src1_connected && src1_input_route == 12'h000)
        else $error("source1 not disconnected");
    chk_bias_apply: assert property (s_bias_wr |-> ##2
        {bias_common_enable, bias_input_enable} == $past(reg_wdata[6:0], 2))
        else $error("bias switches wrong");
endmodule // arcr_regs_assertions

bind arcr_regs arcr_regs_assertions #(.TWELVE_INPUT(TWELVE_INPUT)) u_chk (
    .clk(clk), .srst(srst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid),
    .source1_channel_select(source1_channel_select),
    .source2_channel_select(source2_channel_select),
    .src1_input_route(src1_input_route), .src1_connected(src1_connected),
    .src1_common_route(src1_common_route),
    .src2_input_route(src2_input_route),
    .bias_input_enable(bias_input_enable),
    .bias_common_enable(bias_common_enable));
`default_nettype wire

/* dv/arcr_regs_test.sv */
// Self-checking bench for the routing and bias register block.
`timescale 1ns/1ps
`default_nettype none

module arcr_regs_test
    import arcr_pkg::*;
;
    logic         clk = 1'b0;
    logic         srst = 1'b1;
    logic         wr_en = 1'b0;
    logic         rd_en = 1'b0;
    arcr_byte_t   addr = 8'h00;
    arcr_byte_t   wdata = 8'h00;
    arcr_byte_t   rdata, rd_data;
    logic         rvalid, hit, com1, com2, con1, con2, bcom;
    logic         rp1, rn1, un1, rp2, rn2, un2, conf;
    logic         s_rp1, s_rn1, s_un1, s_con1, s_com1;
    logic         s_rp2, s_rn2, s_un2, s_con2, s_com2;
    arcr_inputs_t s_in1, s_in2;
    arcr_sel_t    sel1, sel2;
    arcr_inputs_t in1, in2;
    logic [5:0]   bin;
    int           err_total = 0;
    int           n_tests = 0;

    // Packed as unsupported, ref pos, ref neg, connected, common, inputs.
    wire [16:0]   out1 = {un1, rp1, rn1, con1, com1, in1};
    wire [16:0]   out2 = {un2, rp2, rn2, con2, com2, in2};
    wire [16:0]   six1 = {s_un1, s_rp1, s_rn1, s_con1, s_com1, s_in1};
    wire [16:0]   six2 = {s_un2, s_rp2, s_rn2, s_con2, s_com2, s_in2};

    always #5 clk = ~clk;

    arcr_regs #(.TWELVE_INPUT(1'b1)) dut (
        .clk(clk), .srst(srst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .reg_rd_valid(rvalid), .reg_addr_hit(hit),
        .source1_channel_select(sel1), .source2_channel_select(sel2),
        .src1_input_route(in1), .src1_common_route(com1),
        .src1_ref_pos_route(rp1), .src1_ref_neg_route(rn1),
        .src1_connected(con1), .src1_unsupported(un1),
        .src2_input_route(in2), .src2_common_route(com2),
        .src2_ref_pos_route(rp2), .src2_ref_neg_route(rn2),
        .src2_connected(con2), .src2_unsupported(un2),
        .route_conflict(conf),
        .bias_input_enable(bin), .bias_common_enable(bcom));

    // Six-input variant fed the same writes, to reach the reference pins.
    arcr_regs #(.TWELVE_INPUT(1'b0)) dut_six (
        .clk(clk), .srst(srst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(),
        .reg_rd_valid(), .reg_addr_hit(),
        .source1_channel_select(), .source2_channel_select(),
        .src1_input_route(s_in1), .src1_common_route(s_com1),
        .src1_ref_pos_route(s_rp1), .src1_ref_neg_route(s_rn1),
        .src1_connected(s_con1), .src1_unsupported(s_un1),
        .src2_input_route(s_in2), .src2_common_route(s_com2),
        .src2_ref_pos_route(s_rp2), .src2_ref_neg_route(s_rn2),
        .src2_connected(s_con2), .src2_unsupported(s_un2),
        .route_conflict(),
        .bias_input_enable(), .bias_common_enable());

    task automatic tally_and_finish();
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [16:0] exp,
                       input logic [16:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input arcr_byte_t a, input arcr_byte_t d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic rd(input arcr_byte_t a);
        int i;
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        for (i = 0; i < 4 && rvalid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 4) begin
            err_total++;
            tally_and_finish();
        end
        rd_data = rdata;
    endtask

    // Expected switch set for one code, packed like out1 and out2.
    function automatic logic [16:0] route_exp(input arcr_sel_t c,
                                              input bit twelve);
        route_exp = 17'h00000;
        if (c <= 4'h5 || (twelve && c <= 4'hB))
            route_exp = {5'b00010, 12'h001 << c};
        else if (c == 4'h6 || c == 4'h7)
            route_exp = {1'b0, c == 4'h6, c == 4'h7, 2'b10, 12'h000};
        else if (c <= 4'hB)
            route_exp = 17'h10000;
        else if (c == 4'hC)
            route_exp = 17'h03000;
    endfunction

    task automatic t_reset_state();
        cmp("selects", 16'h00FF, {sel2, sel1});
        cmp("bias out", 16'h0000, {bcom, bin});
        cmp("src1 out", 17'h00000, out1);
        cmp("src2 out", 17'h00000, out2);
        rd(8'h07);
        cmp("route reg", 16'h00FF, rd_data);
        rd(8'h08);
        cmp("bias reg", 16'h0000, rd_data);
    endtask

    task automatic t_route_codes();
        for (int c = 0; c < 16; c++) begin
            wr(8'h07, {c[3:0], ~c[3:0]});
            cmp("src2 out", route_exp(c[3:0], 1'b1), out2);
            cmp("src1 out", route_exp(~c[3:0], 1'b1), out1);
            cmp("six src2", route_exp(c[3:0], 1'b0), six2);
            cmp("six src1", route_exp(~c[3:0], 1'b0), six1);
            cmp("conflict", 1'b0, conf);
            rd(8'h07);
            cmp("route reg", {c[3:0], ~c[3:0]}, rd_data);
        end
    endtask

    task automatic t_route_conflict();
        arcr_byte_t v [3] = '{8'h33, 8'hCC, 8'hDE};
        foreach (v[i]) begin
            wr(8'h07, v[i]);
            cmp("conflict", i < 2, conf);
        end
    endtask

    task automatic t_bias_combos();
        arcr_byte_t v [5] = '{8'h7F, 8'h80, 8'h55, 8'h2A, 8'h40};
        foreach (v[i]) begin
            wr(8'h08, v[i]);
            cmp("bias out", v[i][6:0], {bcom, bin});
            rd(8'h08);
            cmp("bias reg", v[i], rd_data);
        end
    endtask

    task automatic t_unmapped();
        wr(8'h09, 8'hAA);
        rd(8'h09);
        cmp("stray read", 16'h0000, {hit, rd_data});
        rd(8'h08);
        cmp("bias kept", 16'h0140, {hit, rd_data});
    endtask

    task automatic t_mid_reset();
        wr(8'h07, 8'h12);
        wr(8'h08, 8'h3F);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        t_reset_state();
    endtask

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        t_reset_state();
        t_route_codes();
        t_route_conflict();
        t_bias_combos();
        t_unmapped();
        t_mid_reset();
        tally_and_finish();
    end
endmodule // arcr_regs_test
`default_nettype wire
